/* rws_host.sv */
// host controller model driving commands and status reads
`timescale 1ns/1ps
module rws_host (
    input wire logic clk_i,
    input wire logic accept_i,
    output logic cmd_valid_o,
    output logic [15:0] cmd_o,
    output logic status_read_o
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o = 16'h0000;
        status_read_o = 1'b0;
    end
    task automatic send(input logic [15:0] w, input bit force_it);
        int n;
        n = 0;
        while (!force_it && accept_i !== 1'b1 && n < 1000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        cmd_valid_o = 1'b1;
        cmd_o = w;
        @(posedge clk_i);
        #1;
        cmd_valid_o = 1'b0;
        // released word never looks like the last one
        cmd_o = ~w;
    endtask : send
    task automatic status;
        status_read_o = 1'b1;
        @(posedge clk_i);
        #1;
        status_read_o = 1'b0;
    endtask : status
endmodule : rws_host

/* rws_pkg.sv */
// shared constants and types for the reset and wake sequencer
package rws_pkg;
    localparam int CLK_HZ = 40000000;
    localparam logic [15:0] CMD_SW_RESET = 16'hFE00;
    localparam logic [7:0] CMD_PLL_HI = 8'hCC;
    localparam int RESET_MODE_BIT = 1;
    localparam logic MODE_SENSITIVE_RST = 1'b1;
    localparam int RESET_MAX_MS = 150;
    localparam int HOLD_US = 10;
    localparam int HOLD_CYC = (HOLD_US * (CLK_HZ / 1000000));
    localparam int DEBOUNCE_US = 50;
    localparam int DEBOUNCE_CYC = (DEBOUNCE_US * (CLK_HZ / 1000000));
    localparam int KEY_N = 4;
    localparam int CNT_W = 12;
    typedef enum logic [1:0] {
        RWS_HOLD = 2'b00,
        RWS_RUN = 2'b01,
        RWS_WAKE = 2'b11,
        RWS_KEEP = 2'b10
    } rws_state_t;
endpackage : rws_pkg

/* rws_sync.sv */
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module rws_sync (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic d_i,
    output logic q_o
);
    logic s1;
    logic s2;
    logic s3;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
        end
    end
    // accept a change only once two late stages agree
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            q_o <= 1'b0;
        end else if (s2 == s3) begin
            q_o <= s3;
        end
    end
endmodule : rws_sync

/* rws_top.sv */
// reset decision and oscillator wake sequencing
// Operation
// - reset on power-on, enabled supply glitch, or software reset command.
// - hold reset while supply exceeds ramp by more than threshold.
// - hold reset while supply is below minimum level.
// - reset lasts up to maximum; commands ignored during reset.
// - sensitive and normal modes exist; sensitive is default.
// - normal mode disables glitch detection.
// - sensitive mode resets on fast rise meeting ramp threshold.
// - falling supply resets at mode-dependent low threshold.
// - every reset restores defaults, including sensitive mode.
// - software reset acts exactly like power-on reset.
// - reset-mode bit of PLL command selects normal mode.
// - command code FE00h starts a software reset.
// - controller serialises events and debounces key inputs.
// - oscillator is turned on temporarily for wake, release, status read; a single wake keeps it on until status read.
// - two successive wake events keep oscillator on until status read.
`timescale 1ns/1ps
module rws_top (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic por_i,
    input wire logic ramp_over_i,
    input wire logic vdd_low_i,
    input wire logic vdd_lowest_i,
    input wire logic fast_rise_i,
    input wire logic [rws_pkg::KEY_N-1:0] key_input_i,
    input wire logic wut_expire_i,
    input wire logic lowbat_i,
    input wire logic cmd_valid_i,
    input wire logic [15:0] cmd_i,
    input wire logic status_read_i,
    output logic chip_rst_o,
    output logic sensitive_o,
    output logic cmd_accept_o,
    output logic osc_on_o,
    output logic [rws_pkg::KEY_N-1:0] key_o,
    output logic wake_pend_o
);
    import rws_pkg::*;

    localparam int NSYNC = 5 + KEY_N;
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] syn;
    logic por_s;
    logic ramp_s;
    logic low_s;
    logic lowest_s;
    logic rise_s;
    logic [KEY_N-1:0] key_s;
    logic sw_rst;
    logic rst_cause;
    logic [CNT_W-1:0] hold_cnt;
    logic [KEY_N-1:0] key_q;
    logic [KEY_N-1:0] key_prev;
    logic [CNT_W-1:0] db_cnt [KEY_N];
    logic wut_q;
    logic lowbat_q;
    logic press_ev;
    logic release_ev;
    logic wake_ev;
    rws_state_t state;
    rws_state_t next_state;

    assign raw = {key_input_i, fast_rise_i, vdd_lowest_i, vdd_low_i,
                  ramp_over_i, por_i};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            rws_sync u_sync (
                .clk_i(clk_i),
                .srst_i(srst_i),
                .d_i(raw[gi]),
                .q_o(syn[gi])
            );
        end
    endgenerate

    assign por_s = syn[0];
    assign ramp_s = syn[1];
    assign low_s = syn[2];
    assign lowest_s = syn[3];
    assign rise_s = syn[4];
    assign key_s = syn[NSYNC-1:5];

    assign sw_rst = cmd_accept_o && cmd_valid_i && (cmd_i == CMD_SW_RESET);

    // six causes, same path for software reset
    // glitch only counts in sensitive mode
    assign rst_cause = por_s || sw_rst || low_s && sensitive_o ||
                       lowest_s || ramp_s && !rise_s ||
                       sensitive_o && rise_s && ramp_s;

    // synchronous release after a short hold
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            hold_cnt <= CNT_W'(HOLD_CYC);
            chip_rst_o <= 1'b1;
        end else if (rst_cause) begin
            hold_cnt <= CNT_W'(HOLD_CYC);
            chip_rst_o <= 1'b1;
        end else if (hold_cnt != '0) begin
            hold_cnt <= hold_cnt - 1'b1;
            chip_rst_o <= 1'b1;
        end else begin
            chip_rst_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cmd_accept_o <= 1'b0;
        end else begin
            cmd_accept_o <= !chip_rst_o && !rst_cause;
        end
    end

    // sensitive default, reset restores it, mode bit
    always_ff @(posedge clk_i) begin
        if (srst_i || chip_rst_o) begin
            sensitive_o <= MODE_SENSITIVE_RST;
        end else if (cmd_accept_o && cmd_valid_i &&
                     cmd_i[15:8] == CMD_PLL_HI &&
                     cmd_i[RESET_MODE_BIT]) begin
            sensitive_o <= 1'b0;
        end
    end

    generate
        for (gi = 0; gi < KEY_N; gi++) begin : g_db
            always_ff @(posedge clk_i) begin
                if (srst_i) begin
                    db_cnt[gi] <= '0;
                    key_q[gi] <= 1'b0;
                end else if (key_s[gi] == key_q[gi]) begin
                    db_cnt[gi] <= '0;
                end else if (db_cnt[gi] == CNT_W'(DEBOUNCE_CYC - 1)) begin
                    db_cnt[gi] <= '0;
                    key_q[gi] <= key_s[gi];
                end else begin
                    db_cnt[gi] <= db_cnt[gi] + 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            key_prev <= '0;
            key_o <= '0;
            wut_q <= 1'b0;
            lowbat_q <= 1'b0;
        end else begin
            key_prev <= key_q;
            key_o <= key_q;
            wut_q <= wut_expire_i;
            lowbat_q <= lowbat_i;
        end
    end

    assign press_ev = |(key_q & ~key_prev);
    assign release_ev = |(~key_q & key_prev);
    assign wake_ev = press_ev || (wut_expire_i && !wut_q) ||
                     (lowbat_i && !lowbat_q) || chip_rst_o;

    // events handled one at a time
    always_comb begin
        next_state = state;
        unique case (state)
            RWS_HOLD: begin
                // wake waits for a read; release or read is one pass
                if (wake_ev) begin
                    next_state = RWS_WAKE;
                end else if (release_ev || status_read_i) begin
                    next_state = RWS_RUN;
                end
            end
            RWS_WAKE: begin
                if (wake_ev) begin
                    next_state = RWS_KEEP;
                end else if (status_read_i) begin
                    next_state = RWS_RUN;
                end
            end
            RWS_KEEP: begin
                if (status_read_i) begin
                    next_state = RWS_RUN;
                end
            end
            RWS_RUN: begin
                next_state = RWS_HOLD;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state <= RWS_WAKE;
        end else begin
            state <= next_state;
        end
    end

    // oscillator on while work is pending
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            osc_on_o <= 1'b1;
            wake_pend_o <= 1'b0;
        end else begin
            osc_on_o <= (next_state != RWS_HOLD);
            wake_pend_o <= (next_state == RWS_KEEP);
        end
    end

    a_cmd_blocked: assert property (@(posedge clk_i) disable iff (srst_i)
        chip_rst_o |=> !cmd_accept_o)
        else $error("command accepted during reset");
    a_mode_restore: assert property (@(posedge clk_i) disable iff (srst_i)
        chip_rst_o |=> sensitive_o)
        else $error("mode not restored by reset");
    a_sw_reset: assert property (@(posedge clk_i) disable iff (srst_i)
        sw_rst |=> chip_rst_o)
        else $error("software reset missed");
    a_low_supply: assert property (@(posedge clk_i) disable iff (srst_i)
        lowest_s |=> chip_rst_o [*2])
        else $error("low supply did not hold reset");
    a_normal_glitch: assert property (@(posedge clk_i) disable iff (srst_i)
        !sensitive_o && !chip_rst_o && !por_s && !lowest_s && !sw_rst &&
        !(ramp_s && !rise_s) |=> !chip_rst_o)
        else $error("reset without cause in normal mode");
    sequence s_double_wake;
        state == RWS_WAKE ##0 wake_ev;
    endsequence
    a_double_wake: assert property (@(posedge clk_i) disable iff (srst_i)
        s_double_wake ##1 !status_read_i |=> osc_on_o && wake_pend_o)
        else $error("oscillator dropped after double wake");
    a_wake_osc: assert property (@(posedge clk_i) disable iff (srst_i)
        state == RWS_HOLD && wake_ev |=> ##[0:1] osc_on_o)
        else $error("oscillator not started on wake");
    a_mode_write: assert property (@(posedge clk_i) disable iff (srst_i)
        cmd_accept_o && cmd_valid_i && cmd_i[15:8] == CMD_PLL_HI &&
        cmd_i[RESET_MODE_BIT] && !chip_rst_o |=> !sensitive_o)
        else $error("normal mode not selected");
endmodule : rws_top

/* rws_top_tb.sv */
// self-checking bench for the reset and wake sequencer
`timescale 1ns/1ps
module rws_top_tb;
    import rws_pkg::*;
    logic clk_i, srst_i, por_i, ramp_over_i, vdd_low_i, vdd_lowest_i;
    logic fast_rise_i, wut_expire_i, lowbat_i, cmd_valid_i, status_read_i;
    logic [KEY_N-1:0] key_input_i, key_o;
    logic [15:0] cmd_i;
    logic chip_rst_o, sensitive_o, cmd_accept_o, osc_on_o, wake_pend_o;
    logic [3:0] mon;
    logic [15:0] pll_w;
    int fails = 0;
    int comparisons = 0;
    assign mon = {key_o[0], cmd_accept_o, osc_on_o, chip_rst_o};
    assign pll_w = {CMD_PLL_HI, 8'h00} | (16'h0001 << RESET_MODE_BIT);
    rws_top i_rws_top (.clk_i(clk_i), .srst_i(srst_i), .por_i(por_i),
        .ramp_over_i(ramp_over_i), .vdd_low_i(vdd_low_i),
        .vdd_lowest_i(vdd_lowest_i), .fast_rise_i(fast_rise_i),
        .key_input_i(key_input_i), .wut_expire_i(wut_expire_i),
        .lowbat_i(lowbat_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
        .status_read_i(status_read_i), .chip_rst_o(chip_rst_o),
        .sensitive_o(sensitive_o), .cmd_accept_o(cmd_accept_o),
        .osc_on_o(osc_on_o), .key_o(key_o), .wake_pend_o(wake_pend_o));
    rws_host i_rws_host (.clk_i(clk_i), .accept_i(cmd_accept_o),
        .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i),
        .status_read_o(status_read_i));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic tick(int n = 1);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    task automatic chk(logic seen, logic exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %b expected %b", $time, seen, exp);
        end
    endtask : chk
    task automatic await(int w, logic v, int lim);
        int n;
        n = 0;
        while (mon[w] !== v && n < lim) begin
            tick();
            n++;
        end
        chk(mon[w], v);
    endtask : await
    task automatic give_verdict;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    task automatic s_reset;
        srst_i = 1'b1;
        tick(16);
        chk(chip_rst_o, 1'b1); // held in reset
        chk(sensitive_o, 1'b1); // default mode
        chk(cmd_accept_o, 1'b0); // commands shut
        srst_i = 1'b0;
        await(0, 1'b0, 500); // clean release
        await(2, 1'b1, 3); // commands open
    endtask : s_reset
    task automatic s_wake;
        i_rws_host.status();
        await(1, 1'b0, 10); // osc back off
        wut_expire_i = 1'b1;
        await(1, 1'b1, 5); // wake starts osc
        lowbat_i = 1'b1;
        tick(20);
        chk(wake_pend_o, 1'b1); // second wake kept
        chk(osc_on_o, 1'b1); // osc kept on
        i_rws_host.status();
        tick(5);
        chk(wake_pend_o, 1'b0); // cleared by read
        i_rws_host.status();
        chk(osc_on_o, 1'b1); // read wakes osc
        await(1, 1'b0, 20); // osc off again
        wut_expire_i = 1'b0;
        lowbat_i = 1'b0;
    endtask : s_wake
    task automatic s_mode;
        i_rws_host.send(pll_w, 1'b0);
        tick();
        chk(sensitive_o, 1'b0); // normal mode
        fast_rise_i = 1'b1;
        ramp_over_i = 1'b1;
        vdd_low_i = 1'b1;
        tick(20);
        chk(chip_rst_o, 1'b0); // no glitch reset
        fast_rise_i = 1'b0;
        ramp_over_i = 1'b0;
        vdd_low_i = 1'b0;
    endtask : s_mode
    task automatic s_swrst;
        i_rws_host.send(CMD_SW_RESET, 1'b0);
        tick();
        chk(chip_rst_o, 1'b1); // reset starts
        chk(sensitive_o, 1'b1); // defaults back
        tick(3);
        i_rws_host.send(pll_w, 1'b1);
        await(0, 1'b0, 500); // same as power-on
        await(2, 1'b1, 3); // commands open
        chk(sensitive_o, 1'b1); // ignored in reset
    endtask : s_swrst
    task automatic s_causes;
        logic [4:0] tab [5] = '{5'h10, 5'h08, 5'h04, 5'h0A, 5'h01};
        foreach (tab[k]) begin
            {por_i, ramp_over_i, vdd_lowest_i, fast_rise_i, vdd_low_i} =
                tab[k];
            await(0, 1'b1, 10); // cause
            {por_i, ramp_over_i, vdd_lowest_i, fast_rise_i, vdd_low_i} =
                5'h00;
            await(0, 1'b0, 500); // held then freed
        end
    endtask : s_causes
    task automatic s_key;
        key_input_i = 4'h1;
        tick(1000);
        chk(|key_o, 1'b0); // still debouncing
        await(3, 1'b1, 1100); // press seen
        key_input_i = 4'h0;
        await(3, 1'b0, 2100); // release seen
    endtask : s_key
    initial begin
        {por_i, ramp_over_i, vdd_low_i, vdd_lowest_i} = 4'h0;
        {fast_rise_i, wut_expire_i, lowbat_i} = 3'h0;
        key_input_i = 4'h0;
        srst_i = 1'b1;
        tick();
        s_reset();
        s_wake();
        s_mode();
        s_swrst();
        s_causes();
        s_key();
        give_verdict();
    end
    // run needs about 7000 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        give_verdict();
    end
endmodule : rws_top_tb
